// ---- verilog/sdf_pkg.sv ----
// constants shared by the sinc3 decimation filter block
package sdf_pkg;
	localparam int NCH_DEF     = 8;       // channels per device
	localparam int OUT_W       = 24;      // conversion word width
	localparam int MOD_DIV     = 2;       // modulator rate = core clock / this
	localparam int ORDER       = 3;       // sinc order
	localparam int LOG2_NMAX   = 12;      // log2 of the largest decimation ratio
	localparam int ACC_W       = ORDER * LOG2_NMAX + 1; // integrator width
	localparam int CNT_W       = LOG2_NMAX + 1;         // decimation counter width

	// register offsets
	localparam logic [7:0] CFG1_ADDR   = 8'h01; // configuration_register_one
	localparam logic [7:0] CFG3_ADDR   = 8'h03; // configuration_register_three
	localparam logic [7:0] CHSET_BASE  = 8'h05; // channel_settings_register 0
	localparam logic [7:0] STATUS_ADDR = 8'h0D; // filter status

	// field positions and widths
	localparam int DR_LSB     = 0;  // decimation_rate_field in config one
	localparam int DR_W       = 3;
	localparam int REFBUF_BIT = 7;  // reference_buffer_powerdown, 0 = powered down
	localparam int GAIN_LSB   = 4;  // gain_amplifier code in channel settings
	localparam int GAIN_W     = 3;
	localparam int OVR_BIT    = 0;  // status: sample set overrun, write one to clear
	localparam int AVAIL_BIT  = 1;  // status: output fifo not empty

	// reset values, largest legal codes and fifo depth
	localparam logic [DR_W-1:0]   DR_RST     = 3'h6;
	localparam logic              REFBUF_RST = 1'b0;
	localparam logic [GAIN_W-1:0] GAIN_RST   = 3'h6;
	localparam logic [DR_W-1:0]   DR_MAXCODE = 3'h6;
	localparam logic [GAIN_W-1:0] GAIN_MAXCODE = 3'h6;
	localparam int FIFO_DEPTH  = 16;
endpackage

// ---- verilog/sdf_fifo.sv ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module sdf_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  empty,
	output logic                  full
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // storage words
	logic [AW:0]      wr_ptr_r;      // write pointer with wrap bit
	logic [AW:0]      rd_ptr_r;      // read pointer with wrap bit
	logic             push;
	logic             pop;

	// full when pointers differ only in the wrap bit
	assign empty     = (wr_ptr_r == rd_ptr_r);
	assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign push      = in_valid && !full;
	assign pop       = out_ready && !empty;
	assign out_data  = mem[rd_ptr_r[AW-1:0]];

	// storage write, no reset needed on data
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	// pointer update
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

// ---- verilog/sdf_sinc3_filter.sv ----
// multichannel sinc3 decimation path with its configuration registers
`timescale 1ns/100ps
// Contract
// R1 - modulator sample rate is core clock over two
// R2 - each channel has its own sinc3 filter
// R3 - one modulator bit per sample, decimated words out
// R4 - response is sinc to the third power
// R5 - one global rate field sets all channels
// R6 - results are 24-bit words
// R7 - per-channel gain code selects seven gains
// R8 - config three bit powers reference buffer
// R9 - reference buffer powered down after reset
// R10 - integrators wide enough for largest ratio
module sdf_sinc3_filter #(
	parameter int NCH   = sdf_pkg::NCH_DEF,
	parameter int DEPTH = sdf_pkg::FIFO_DEPTH
) (
	input  wire logic                               core_clk,
	input  wire logic                               reset,
	input  wire logic [7:0]                         reg_addr,
	input  wire logic [7:0]                         reg_wdata,
	input  wire logic                               reg_wr,
	input  wire logic                               reg_rd,
	output logic [7:0]                              reg_rdata,
	output logic                                    mod_clk,
	input  wire logic [NCH-1:0]                     mod_bits,
	output logic                                    ref_buf_enable,
	output logic [NCH*sdf_pkg::GAIN_W-1:0]          gain_code,
	output logic [NCH*5-1:0]                        gain_value,
	output logic                                    out_valid,
	input  wire logic                               out_ready,
	output logic [sdf_pkg::OUT_W-1:0]               out_data,
	output logic [$clog2(NCH)-1:0]                  out_chan
);
	// widths derived from the package and the channel count
	localparam int CH_W  = $clog2(NCH);
	localparam int AW    = sdf_pkg::ACC_W;
	localparam int OW    = sdf_pkg::OUT_W;
	localparam int FW    = OW + CH_W;
	localparam int GW    = sdf_pkg::GAIN_W;

	// rate code with the reserved code folded onto the fastest legal rate
	function automatic logic [sdf_pkg::DR_W-1:0] clamp_rate(
		input logic [sdf_pkg::DR_W-1:0] c);
		clamp_rate = (c > sdf_pkg::DR_MAXCODE) ? sdf_pkg::DR_MAXCODE : c;
	endfunction

	// address decode of one channel settings register, shared by write and read
	function automatic logic is_chset(input logic [7:0] a, input int n);
		is_chset = (a == sdf_pkg::CHSET_BASE + 8'(n));
	endfunction

	// decimation ratio from the rate code; reserved codes use the fastest rate
	function automatic logic [sdf_pkg::CNT_W-1:0] ratio(input logic [sdf_pkg::DR_W-1:0] c);
		logic [sdf_pkg::DR_W-1:0] k;
		k = clamp_rate(c);
		ratio = {1'b1, {(sdf_pkg::CNT_W-1){1'b0}}} >> k;
	endfunction

	// gain factor for a gain code; reserved codes read as zero
	function automatic logic [4:0] gain_of(input logic [GW-1:0] c);
		unique case (c)
			3'h0:    gain_of = 5'h01;
			3'h1:    gain_of = 5'h02;
			3'h2:    gain_of = 5'h04;
			3'h3:    gain_of = 5'h06;
			3'h4:    gain_of = 5'h08;
			3'h5:    gain_of = 5'h0C;
			3'h6:    gain_of = 5'h18;
			default: gain_of = 5'h00;
		endcase
	endfunction

	// centre the unsigned comb result, align to the msb and saturate
	function automatic logic [OW-1:0] scale(input logic [AW-1:0] c,
		input logic [sdf_pkg::DR_W-1:0] dc);
		logic [sdf_pkg::DR_W-1:0] k;
		logic [AW-1:0]            half;
		logic [AW-1:0]            cen;
		logic [AW-1:0]            al;
		k    = clamp_rate(dc);
		// n cubed is a power of two, so a shift by three times k lines it up
		half = {2'b01, {(AW-2){1'b0}}} >> (sdf_pkg::ORDER * k);
		cen  = c - half;
		al   = cen << (sdf_pkg::ORDER * k);
		// full-scale ones give exactly +half, one lsb past the top code
		if (!al[AW-1] && al[AW-2]) begin
			scale = {1'b0, {(OW-1){1'b1}}};
		end else begin
			scale = al[AW-2 -: OW];
		end
	endfunction

	// configuration state
	logic [sdf_pkg::DR_W-1:0] dr_r;          // global decimation_rate_field
	logic                     refbuf_on_r;   // reference buffer enable
	logic [GW-1:0]            gain_r [NCH];  // per-channel gain_amplifier code
	logic                     ovr_r;         // sticky sample set overrun
	logic [7:0]               rdata_r;       // read data register

	// modulator timing and filter state
	logic                         mod_ph_r;     // modulator clock phase
	logic                         mod_stb;      // one sample per modulator cycle
	logic [sdf_pkg::CNT_W-1:0]    dec_cnt_r;    // samples in current output period
	logic                         dec_evt;      // last sample of the period
	logic [AW-1:0]                i1_r [NCH];   // first integrator
	logic [AW-1:0]                i2_r [NCH];   // second integrator
	logic [AW-1:0]                i3_r [NCH];   // third integrator
	logic [AW-1:0]                d1_r [NCH];   // comb delays
	logic [AW-1:0]                d2_r [NCH];
	logic [AW-1:0]                d3_r [NCH];
	logic [AW-1:0]                c1_w [NCH];   // comb outputs
	logic [AW-1:0]                c2_w [NCH];
	logic [AW-1:0]                c3_w [NCH];

	// output staging and the rate register write strobe
	logic [OW-1:0]   hold_r [NCH];   // samples waiting for the fifo
	logic            pend_r;         // staging holds an unsent set
	logic [CH_W-1:0] idx_r;          // next channel to push
	logic            f_ready;        // fifo has room for a word
	logic            f_empty;        // fifo holds nothing
	logic [FW-1:0]   f_out;          // channel index and sample from the fifo
	logic            dr_wr;          // write to the rate register

	// a config one write also restarts the output period below
	assign dr_wr = reg_wr && (reg_addr == sdf_pkg::CFG1_ADDR);

	// global rate code, shared by every channel
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dr_r <= sdf_pkg::DR_RST;
		end else if (dr_wr) begin
			dr_r <= reg_wdata[sdf_pkg::DR_LSB +: sdf_pkg::DR_W]; // R5
		end
	end

	// reference buffer enable; reset leaves it powered down so an external
	// reference can be driven before software has decided anything
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			refbuf_on_r <= sdf_pkg::REFBUF_RST; // R9
		end else if (reg_wr && reg_addr == sdf_pkg::CFG3_ADDR) begin
			refbuf_on_r <= reg_wdata[sdf_pkg::REFBUF_BIT]; // R8
		end
	end

	// per-channel gain codes, one settings register per channel
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int n = 0; n < NCH; n++) begin
				gain_r[n] <= sdf_pkg::GAIN_RST;
			end
		end else if (reg_wr) begin
			for (int n = 0; n < NCH; n++) begin
				if (is_chset(reg_addr, n)) begin
					gain_r[n] <= reg_wdata[sdf_pkg::GAIN_LSB +: GW]; // R7
				end
			end
		end
	end

	// overrun flag: a new set while the last is unsent; set beats clear
	// so a loss in the clearing cycle is never hidden from software
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ovr_r <= 1'b0;
		end else if (dec_evt && pend_r) begin
			ovr_r <= 1'b1;
		end else if (reg_wr && reg_addr == sdf_pkg::STATUS_ADDR
			&& reg_wdata[sdf_pkg::OVR_BIT]) begin
			ovr_r <= 1'b0;
		end
	end

	// register reads, data valid the cycle after the strobe only
	// a plain port never stalls, so there is no wait state to honour
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			rdata_r <= 8'h00;
			if (reg_addr == sdf_pkg::CFG1_ADDR) begin
				rdata_r[sdf_pkg::DR_LSB +: sdf_pkg::DR_W] <= dr_r;
			end
			if (reg_addr == sdf_pkg::CFG3_ADDR) begin
				rdata_r[sdf_pkg::REFBUF_BIT] <= refbuf_on_r;
			end
			if (reg_addr == sdf_pkg::STATUS_ADDR) begin
				// overrun is sticky, the fifo flag is live
				rdata_r[sdf_pkg::OVR_BIT]   <= ovr_r;
				rdata_r[sdf_pkg::AVAIL_BIT] <= !f_empty;
			end
			for (int n = 0; n < NCH; n++) begin
				if (is_chset(reg_addr, n)) begin
					rdata_r[sdf_pkg::GAIN_LSB +: GW] <= gain_r[n];
				end
			end
		end else begin
			// unmapped or idle cycles read as zero
			rdata_r <= 8'h00;
		end
	end

	// read data and buffer control come straight from their flops
	assign reg_rdata      = rdata_r;
	assign ref_buf_enable = refbuf_on_r;

	// gain codes and factors to the analog front end
	// code seven is reserved and reads as no gain at all
	always_comb begin
		for (int n = 0; n < NCH; n++) begin
			gain_code[n*GW +: GW] = gain_r[n];
			gain_value[n*5 +: 5]  = gain_of(gain_r[n]); // R7
		end
	end

	// modulator clock: toggles every core cycle, so it runs at half rate
	// a registered toggle keeps the modulator clock free of glitches
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mod_ph_r <= 1'b0;
		end else begin
			mod_ph_r <= !mod_ph_r; // R1
		end
	end

	assign mod_clk = mod_ph_r;
	// the bit is taken once per modulator period, on the high phase;
	// the modulator moves its bits on the other phase, so they are settled
	assign mod_stb = mod_ph_r; // R1
	// output point: the last modulator sample of the current period
	assign dec_evt = mod_stb && (dec_cnt_r == ratio(dr_r) - 1'b1);

	// output period counter; a rate change restarts the period,
	// so the first sets after a rate change are unsettled
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dec_cnt_r <= '0;
		end else if (dr_wr) begin
			dec_cnt_r <= '0;
		end else if (dec_evt) begin
			dec_cnt_r <= '0; // R5
		end else if (mod_stb) begin
			dec_cnt_r <= dec_cnt_r + 1'b1;
		end
	end

	// three cascaded integrators per channel; wraparound is harmless
	// because the width covers the full growth at the largest ratio
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int n = 0; n < NCH; n++) begin
				i1_r[n] <= '0;
				i2_r[n] <= '0;
				i3_r[n] <= '0;
			end
		end else if (mod_stb) begin
			for (int n = 0; n < NCH; n++) begin
				i1_r[n] <= i1_r[n] + AW'(mod_bits[n]); // R3 R10
				i2_r[n] <= i2_r[n] + i1_r[n];          // R4
				i3_r[n] <= i3_r[n] + i2_r[n];          // R4
			end
		end
	end

	// three combs at the decimated rate, one set per channel;
	// they settle every cycle but only matter at an output point
	always_comb begin
		for (int n = 0; n < NCH; n++) begin
			c1_w[n] = i3_r[n] - d1_r[n]; // R2 R4
			c2_w[n] = c1_w[n] - d2_r[n];
			c3_w[n] = c2_w[n] - d3_r[n];
		end
	end

	// comb delay update at each output point
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int n = 0; n < NCH; n++) begin
				d1_r[n] <= '0;
				d2_r[n] <= '0;
				d3_r[n] <= '0;
			end
		end else if (dec_evt) begin
			for (int n = 0; n < NCH; n++) begin
				d1_r[n] <= i3_r[n];
				d2_r[n] <= c1_w[n];
				d3_r[n] <= c2_w[n];
			end
		end
	end

	// sample capture; a set still waiting in staging is replaced here
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int n = 0; n < NCH; n++) begin
				hold_r[n] <= '0;
			end
		end else if (dec_evt) begin
			for (int n = 0; n < NCH; n++) begin
				hold_r[n] <= scale(c3_w[n], dr_r); // R6
			end
		end
	end

	// push the set into the fifo one channel per cycle;
	// a stalled reader backs up here, and a late set overwrites it;
	// the next channel goes out on each cycle, other than an output point, that the fifo has room
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pend_r <= 1'b0;
			idx_r  <= '0;
		end else if (dec_evt) begin
			pend_r <= 1'b1;
			idx_r  <= '0;
		end else if (pend_r && f_ready) begin
			if (idx_r == CH_W'(NCH - 1)) begin
				pend_r <= 1'b0;
				idx_r  <= '0;
			end else begin
				idx_r <= idx_r + 1'b1;
			end
		end
	end

	// the fifo lets a slow reader lag by up to DEPTH words
	sdf_fifo #(
		.WIDTH (FW),
		.DEPTH (DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (pend_r && !dec_evt),
		.in_ready  (f_ready),
		.in_data   ({idx_r, hold_r[idx_r]}),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (f_out),
		.empty     (f_empty),
		.full      ()
	);

	// split the stored word back into channel index and sample
	assign out_chan = f_out[FW-1 -: CH_W];
	assign out_data = f_out[OW-1:0];
endmodule

// ---- testbench/sdf_sinc3_properties.sv ----
// concurrent checks on the ports of the sinc3 decimation block
`timescale 1ns/100ps
module sdf_sinc3_properties #(
	parameter int NCH = 8
) (
	input wire logic                           core_clk,
	input wire logic                           reset,
	input wire logic [7:0]                     reg_addr,
	input wire logic [7:0]                     reg_wdata,
	input wire logic                           reg_wr,
	input wire logic                           reg_rd,
	input wire logic [7:0]                     reg_rdata,
	input wire logic                           mod_clk,
	input wire logic                           ref_buf_enable,
	input wire logic [NCH*sdf_pkg::GAIN_W-1:0] gain_code,
	input wire logic [NCH*5-1:0]               gain_value,
	input wire logic                           out_valid,
	input wire logic                           out_ready,
	input wire logic [sdf_pkg::OUT_W-1:0]      out_data,
	input wire logic [$clog2(NCH)-1:0]         out_chan
);
	// gain per code; the reserved code decodes to zero
	localparam logic [4:0] GT [8] = '{5'h01, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h18, 5'h00};
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_MOD_RISE: assert property (!reset && !mod_clk |=> mod_clk)
		else $error("modulator clock missed a rise");
	AST_MOD_FALL: assert property (mod_clk |=> !mod_clk)
		else $error("modulator clock missed a fall");
	AST_GAIN_DECODE: assert property (gain_value[4:0] == GT[gain_code[2:0]])
		else $error("gain decode wrong");
	AST_GAIN_WRITE: assert property (reg_wr && reg_addr == sdf_pkg::CHSET_BASE
		|=> gain_code[2:0] == $past(reg_wdata[6:4])) else $error("gain code not stored");
	AST_REF_WRITE: assert property (reg_wr && reg_addr == sdf_pkg::CFG3_ADDR
		|=> ref_buf_enable == $past(reg_wdata[7])) else $error("buffer bit not applied");
	AST_REF_HOLD: assert property (!(reg_wr && reg_addr == sdf_pkg::CFG3_ADDR)
		|=> $stable(ref_buf_enable)) else $error("buffer bit moved without a write");
	AST_RESET_REF: assert property ($fell(reset) |-> !ref_buf_enable)
		else $error("buffer not powered down after reset");
	AST_VALID_HOLD: assert property (out_valid && !out_ready
		|=> out_valid && $stable(out_data) && $stable(out_chan)) else $error("word lost");
	AST_DR_READ: assert property (reg_wr && reg_addr == sdf_pkg::CFG1_ADDR ##2
		reg_rd && reg_addr == sdf_pkg::CFG1_ADDR |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3))
		else $error("rate field read back wrong");
	// main scenarios reached
	COV_POP: cover property (out_valid && out_ready);
	COV_STALL: cover property (out_valid && !out_ready);
	COV_REF: cover property (reg_wr && reg_addr == sdf_pkg::CFG3_ADDR);
endmodule
bind sdf_sinc3_filter sdf_sinc3_properties #(.NCH(NCH)) sdf_sinc3_properties_inst (
	.core_clk       (core_clk),
	.reset          (reset),
	.reg_addr       (reg_addr),
	.reg_wdata      (reg_wdata),
	.reg_wr         (reg_wr),
	.reg_rd         (reg_rd),
	.reg_rdata      (reg_rdata),
	.mod_clk        (mod_clk),
	.ref_buf_enable (ref_buf_enable),
	.gain_code      (gain_code),
	.gain_value     (gain_value),
	.out_valid      (out_valid),
	.out_ready      (out_ready),
	.out_data       (out_data),
	.out_chan       (out_chan)
);

// ---- testbench/sdf_mod_model.sv ----
// behavioural modulator: a steady level on channel zero, its inverse on one
`timescale 1ns/100ps
module sdf_mod_model (
	input  wire logic core_clk,
	input  wire logic mod_clk,
	input  wire logic level,
	output logic [1:0] mod_bits
);
	// bits move only on edges the filter skips, so they are steady when sampled
	always_ff @(posedge core_clk) begin
		if (!mod_clk) begin
			mod_bits <= {~level, level};
		end
	end
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the sinc3 decimation block
`timescale 1ns/100ps
module tb;
	localparam int NCH = 2;  // two channels keep the run short
	localparam logic [4:0] GT [7] = '{5'h01, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h18};
	logic        core_clk = 0;
	logic        reset = 1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic        out_ready = 1;
	logic        level = 1;  // modulator level of channel zero
	logic [7:0]  reg_rdata, v;
	logic        mod_clk, ref_buf_enable, out_valid, out_chan, c;
	logic [1:0]  mod_bits;
	logic [5:0]  gain_code;
	logic [9:0]  gain_value;
	logic [23:0] out_data, d0, d1;
	int          n_fail = 0;
	int          num_checks = 0;
	time         t0;
	always #5 core_clk = ~core_clk;
	sdf_sinc3_filter #(
		.NCH (NCH)
	) sdf_sinc3_filter_inst (
		.core_clk       (core_clk),
		.reset          (reset),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.mod_clk        (mod_clk),
		.mod_bits       (mod_bits),
		.ref_buf_enable (ref_buf_enable),
		.gain_code      (gain_code),
		.gain_value     (gain_value),
		.out_valid      (out_valid),
		.out_ready      (out_ready),
		.out_data       (out_data),
		.out_chan       (out_chan)
	);
	sdf_mod_model sdf_mod_model_inst (.core_clk, .mod_clk, .level, .mod_bits);
	task chk(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
		#1;
	endtask
	task rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 v = reg_rdata;
	endtask
	// waits for a word at the settled half of the cycle; the next edge pops it
	task take(output logic [23:0] x);
		int k;
		k = 0;
		@(negedge core_clk);
		while (out_valid !== 1'b1 && k < 5000) begin
			@(negedge core_clk);
			k++;
		end
		chk(24'(out_valid), 24'h1);
		x = out_data;
		c = out_chan;
		@(posedge core_clk);
	endtask
	task t_reset;
		rd(sdf_pkg::CFG3_ADDR);
		chk(v[7], 1'b0);
		chk(ref_buf_enable, 1'b0);
		rd(sdf_pkg::CFG1_ADDR);
		chk(v[2:0], sdf_pkg::DR_RST);
		chk(gain_code, {2{sdf_pkg::GAIN_RST}});
	endtask
	task t_gain;
		for (int g = 0; g < 7; g++) begin
			wr(sdf_pkg::CHSET_BASE, {1'b0, 3'(g), 4'h0});
			wr(sdf_pkg::CHSET_BASE + 8'h01, {1'b0, 3'(6 - g), 4'h0});
			chk(gain_value, {GT[6 - g], GT[g]});
		end
		rd(sdf_pkg::CHSET_BASE + 8'h01);
		chk(v[6:4], 3'h0);
		wr(sdf_pkg::CHSET_BASE, 8'h70);
		chk(gain_value[4:0], 5'h00);
	endtask
	task t_ref;
		wr(sdf_pkg::CFG3_ADDR, 8'h80);
		chk(ref_buf_enable, 1'b1);
		rd(sdf_pkg::CFG3_ADDR);
		chk(v[7], 1'b1);
		wr(sdf_pkg::CFG3_ADDR, 8'h00);
		chk(ref_buf_enable, 1'b0);
	endtask
	// steady input, five sets: the last two are settled full-scale codes
	task t_rate(input logic lv, input logic [2:0] dr, input int n);
		@(posedge core_clk);
		level <= lv;
		wr(sdf_pkg::CFG1_ADDR, {5'h00, dr});
		rd(sdf_pkg::CFG1_ADDR);
		chk(v[2:0], dr);
		for (int s = 0; s < 5; s++) begin
			do take(d0); while (c !== 1'b0);
			if (s == 4) chk(24'(($time - t0) / 10), 24'(2 * n));
			t0 = $time;
			take(d1);
			chk(c, 1'b1);
			if (s > 2) chk(d0, lv ? 24'h7FFFFF : 24'h800000);
			if (s > 2) chk(d1, lv ? 24'h800000 : 24'h7FFFFF);
		end
	endtask
	// stall the consumer until the buffer refuses, then drain and clear
	task t_ovr;
		@(posedge core_clk);
		out_ready <= 0;
		repeat (3000) @(posedge core_clk);
		rd(sdf_pkg::STATUS_ADDR);
		chk(v[1:0], 2'b11);
		@(posedge core_clk);
		out_ready <= 1;
		repeat (40) @(posedge core_clk);
		wr(sdf_pkg::STATUS_ADDR, 8'h01);
		rd(sdf_pkg::STATUS_ADDR);
		chk(v[0], 1'b0);
	endtask
	task report_and_stop;
		if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 0;
		t_reset;
		t_gain;
		t_ref;
		t_rate(1'b1, 3'h6, 64);
		t_rate(1'b1, 3'h7, 64);
		t_rate(1'b0, 3'h5, 128);
		t_ovr;
		report_and_stop;
	end
	// a hang is cut short well past the expected length of the run
	initial begin
		#200_000;
		n_fail++;
		report_and_stop;
	end
endmodule
